// ==== utmi_ctrl_pkg.sv ====
// package: register map, field layout and reset values of the utmi control bank
// How it works
// - bits 14:12 of setup pick crystal frequency code, reset value 1.
// - setup bit 11 enables the id pin detection pad, reset 0.
// - setup bit 10 enables link power management, reset 0.
// - setup bit 9 enables the transceiver pll, reset 0.
// - setup bit 8 enables transmit bit stuffing, reset 0.
// - setup bits 7 and 6 enable minus and plus line pulldowns, reset 0.
// - setup bit 5 drives suspend level directly, reset 1.
// - setup bits 4:3 drive operating mode directly, reset 1.
// - setup bit 2 drives termination select directly, reset 1.
// - setup bits 1:0 drive transceiver select directly, reset 1.
// - reset bit 1 holds interface logic in reset while 1, reset 1.
// - reset bit 0 releases transceiver when 1, reset 0.
// - shim bit 1 routes line state, else active and valid, to flag ports.
// - shim bit 0 gates the valid flag with active.
// - status bit 3 reports id pad above 100 kilohm to ground.
// - status bit 2 reports no device attached.
// - status bits 1:0 report current line state.
// - registers sit at index 0xf008, 0xf00a, 0xf00c, 0xf011; upper bits reserved.
package utmi_ctrl_pkg;
   localparam int ADDR_W = 18;
   // printed offsets are word indices; byte address is four times the index
   localparam logic [15:0] IDX_SETUP = 16'hf008;
   localparam logic [15:0] IDX_RESET = 16'hf00a;
   localparam logic [15:0] IDX_SHIM = 16'hf00c;
   localparam logic [15:0] IDX_STATUS = 16'hf011;

   typedef struct packed {
      logic [2:0] osc_freq;
      logic id_pad_enable;
      logic link_power_mgmt_enable;
      logic pll_enable;
      logic tx_stuffing_enable;
      logic minus_line_pulldown;
      logic plus_line_pulldown;
      logic suspend_drive_value;
      logic [1:0] op_mode_drive;
      logic termination_drive;
      logic [1:0] transceiver_select_drive;
   } setup_t;

   typedef struct packed {
      logic macro_interface_reset;
      logic transceiver_power_on_reset;
   } reset_ctl_t;

   typedef struct packed {
      logic flag_mode_linestate;
      logic gate_valid_with_active;
   } shim_t;

   typedef struct packed {
      logic self_test_passed;
      logic id_pad_high;
      logic no_device_attached;
      logic [1:0] line_state;
   } status_t;

   localparam int SETUP_W = 15;
   localparam int RESET_W = 2;
   localparam int SHIM_W = 2;
   localparam int STATUS_W = 5;

   localparam setup_t SETUP_RST = '{osc_freq: 3'h1, id_pad_enable: 1'b0, link_power_mgmt_enable: 1'b0,
      pll_enable: 1'b0, tx_stuffing_enable: 1'b0, minus_line_pulldown: 1'b0, plus_line_pulldown: 1'b0,
      suspend_drive_value: 1'b1, op_mode_drive: 2'h1, termination_drive: 1'b1, transceiver_select_drive: 2'h1};
   localparam reset_ctl_t RESET_RST = '{macro_interface_reset: 1'b1, transceiver_power_on_reset: 1'b0};
   localparam shim_t SHIM_RST = '{flag_mode_linestate: 1'b0, gate_valid_with_active: 1'b0};
   localparam status_t STATUS_RST = '{self_test_passed: 1'b0, id_pad_high: 1'b0, no_device_attached: 1'b0,
      line_state: 2'h0};

   // answer returned to an unmapped address
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ==== usb_phy_utmi_control_regs.sv ====
// utmi control/status register bank on avalon-mm, drives static utmi levels and the flag ports
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module usb_phy_utmi_control_regs (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [utmi_ctrl_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [1:0] o_avs_response,
   input wire logic [1:0] i_utmi_line_state,
   input wire logic i_utmi_rx_active,
   input wire logic i_utmi_rx_valid,
   input wire logic i_phy_host_disconnect,
   input wire logic i_phy_id_high,
   input wire logic i_phy_self_test_ok,
   output utmi_ctrl_pkg::setup_t o_phy_setup,
   output logic o_utmi_reset,
   output logic o_phy_reset,
   output logic o_flag_port_a,
   output logic o_flag_port_b
);
   import utmi_ctrl_pkg::*;

   setup_t setup_q;
   reset_ctl_t reset_q;
   shim_t shim_q;
   status_t stat_meta_q;
   status_t stat_q;
   logic [1:0] rxf_meta_q;
   logic [1:0] rxf_q;
   logic ack_q;
   logic [31:0] rdata_d;
   logic [31:0] wmask;
   logic [15:0] idx;
   logic hit;
   logic req;

   // byte address carries two zero low bits; index is the rest
   assign idx = i_avs_address[ADDR_W-1:2];
   assign req = (i_avs_read | i_avs_write) & ~ack_q;
   assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

   // one wait cycle per access: registered answer keeps readdata off the address path
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

   always_comb begin
      rdata_d = UNMAPPED_DATA;
      hit = 1'b1;
      case (idx)
         IDX_SETUP: rdata_d = {{(32-SETUP_W){1'b0}}, setup_q};
         IDX_RESET: rdata_d = {{(32-RESET_W){1'b0}}, reset_q};
         IDX_SHIM: rdata_d = {{(32-SHIM_W){1'b0}}, shim_q};
         IDX_STATUS: rdata_d = {{(32-STATUS_W){1'b0}}, stat_q};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_avs_readdata <= 32'h0000_0000;
         o_avs_response <= 2'b00;
      end else if (req) begin
         o_avs_readdata <= i_avs_read ? rdata_d : 32'h0000_0000;
         o_avs_response <= hit ? 2'b00 : 2'b11;
      end
   end

   // writes land on the first request cycle; master holds it until waitrequest drops
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         setup_q <= SETUP_RST;
      end else if (req && i_avs_write && idx == IDX_SETUP) begin
         setup_q <= setup_t'((setup_q & ~wmask[SETUP_W-1:0]) | (i_avs_writedata[SETUP_W-1:0] & wmask[SETUP_W-1:0]));
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         reset_q <= RESET_RST;
      end else if (req && i_avs_write && idx == IDX_RESET && i_avs_byteenable[0]) begin
         reset_q <= reset_ctl_t'(i_avs_writedata[RESET_W-1:0]);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         shim_q <= SHIM_RST;
      end else if (req && i_avs_write && idx == IDX_SHIM && i_avs_byteenable[0]) begin
         shim_q <= shim_t'(i_avs_writedata[SHIM_W-1:0]);
      end
   end

   // status pins are asynchronous to i_mclk
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         stat_meta_q <= STATUS_RST;
         stat_q <= STATUS_RST;
         rxf_meta_q <= 2'b00;
         rxf_q <= 2'b00;
      end else begin
         stat_meta_q <= '{self_test_passed: i_phy_self_test_ok, id_pad_high: i_phy_id_high,
            no_device_attached: i_phy_host_disconnect, line_state: i_utmi_line_state};
         stat_q <= stat_meta_q;
         rxf_meta_q <= {i_utmi_rx_active, i_utmi_rx_valid};
         rxf_q <= rxf_meta_q;
      end
   end

   assign o_phy_setup = setup_q;
   assign o_utmi_reset = reset_q.macro_interface_reset;
   assign o_phy_reset = ~reset_q.transceiver_power_on_reset;

   // flags are registered so the processor ports never see a select glitch
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_flag_port_a <= 1'b0;
         o_flag_port_b <= 1'b0;
      end else if (shim_q.flag_mode_linestate) begin
         o_flag_port_a <= stat_q.line_state[1];
         o_flag_port_b <= stat_q.line_state[0];
      end else begin
         o_flag_port_a <= rxf_q[1];
         o_flag_port_b <= shim_q.gate_valid_with_active ? (rxf_q[0] & rxf_q[1]) : rxf_q[0];
      end
   end
endmodule

// ==== utmi_ctrl_sva.sv ====
// assertion checker for the utmi control bank ports
`timescale 1ns/100ps
module utmi_ctrl_sva (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic [31:0] o_avs_readdata,
   input wire logic [1:0] i_utmi_line_state,
   input wire logic i_utmi_rx_active,
   input wire logic i_utmi_rx_valid,
   input wire utmi_ctrl_pkg::setup_t o_phy_setup,
   input wire logic o_utmi_reset,
   input wire logic o_phy_reset,
   input wire logic o_flag_port_a,
   input wire logic o_flag_port_b
);
   import utmi_ctrl_pkg::*;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // flags only follow pins once the sync chain has flushed after reset
   logic [2:0] age_q;
   always_ff @(posedge i_mclk) age_q <= i_rst ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
   wire rq = i_avs_read | i_avs_write;
   wire wr_take = i_avs_write & o_avs_waitrequest;
   wire [1:0] fa_pins = {i_utmi_rx_active, i_utmi_line_state[1]};
   wire [2:0] fb_pins = {i_utmi_rx_valid, i_utmi_rx_active, i_utmi_line_state[0]};
   sequence s_take; rq && o_avs_waitrequest; endsequence
   property p_one_wait; s_take |=> !o_avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
   property p_idle; !rq |-> !o_avs_waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("wait without request");
   property p_rst; $past(i_rst) |-> o_phy_setup == SETUP_RST && o_utmi_reset && o_phy_reset; endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_take; !$stable({o_phy_setup, o_utmi_reset, o_phy_reset}) |-> $past(wr_take); endproperty
   a_take: assert property (p_take) else $error("control changed without write");
   property p_hold; !rq |=> $stable(o_avs_readdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_fa; age_q == 3'h7 && $past(fa_pins, 3) inside {2'h0, 2'h3}
      |-> o_flag_port_a == $past(i_utmi_rx_active, 3); endproperty
   a_fa: assert property (p_fa) else $error("flag a wrong");
   property p_fb; age_q == 3'h7 && $past(fb_pins, 3)
      inside {3'h0, 3'h7} |-> o_flag_port_b == $past(i_utmi_rx_valid, 3); endproperty
   a_fb: assert property (p_fb) else $error("flag b wrong");
   property p_frst; $past(i_rst) |-> !o_flag_port_a && !o_flag_port_b; endproperty
   a_frst: assert property (p_frst) else $error("flag not cleared");
endmodule
bind usb_phy_utmi_control_regs utmi_ctrl_sva u_sva (.*);

// ==== utmi_phy_model.sv ====
// transceiver model: drives status and receive pins
`timescale 1ns/100ps
module utmi_phy_model (
   input wire logic i_mclk,
   input wire logic i_phy_reset,
   input wire logic i_utmi_reset,
   input wire logic [6:0] i_drive,
   output logic [6:0] o_pins
);
   // all pins quiet while the phy is held; only the receive pins quiet while the interface is held
   always_ff @(posedge i_mclk) o_pins <= i_phy_reset ? 7'h00 : i_utmi_reset ? i_drive & 7'h7c : i_drive;
endmodule

// ==== testbench.sv ====
// self-checking bench for the utmi control bank
`timescale 1ns/100ps
module testbench;
   import utmi_ctrl_pkg::*;
   logic i_mclk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [17:0] i_avs_address = 18'h0_0000;
   logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata, rdat;
   logic [3:0] i_avs_byteenable = 4'hf;
   logic o_avs_waitrequest, o_utmi_reset, o_phy_reset, o_flag_port_a, o_flag_port_b;
   logic [1:0] o_avs_response, i_utmi_line_state, rsp;
   logic i_utmi_rx_active, i_utmi_rx_valid, i_phy_host_disconnect, i_phy_id_high, i_phy_self_test_ok;
   setup_t o_phy_setup;
   logic [6:0] drv = 7'h00, p;
   logic [15:0] s = 16'h314f;
   logic [15:0] ix[5] = '{IDX_SETUP, IDX_RESET, IDX_SHIM, IDX_STATUS, 16'hf009};
   int miscompares = 0, samples_checked = 0, cyc = 0, k;
   int m[4] = '{32'h0000_102d, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000};
   int msk[3] = '{32'h0000_7fff, 32'h0000_0003, 32'h0000_0003};
   usb_phy_utmi_control_regs u_dut (.*);
   utmi_phy_model u_phy (.i_mclk(i_mclk), .i_phy_reset(o_phy_reset), .i_utmi_reset(o_utmi_reset), .i_drive(drv),
      .o_pins({i_phy_self_test_ok, i_phy_id_high, i_phy_host_disconnect, i_utmi_line_state, i_utmi_rx_active,
      i_utmi_rx_valid}));
   initial forever #4 i_mclk = ~i_mclk;
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] expv(input int j);
      p = m[1][0] ? (m[1][1] ? drv & 7'h7c : drv) : 7'h00;
      return j == 3 ? {27'h0, p[6:2]} : j == 4 ? 32'h0000_0000 : m[j];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input int j, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_avs_address <= {ix[j], 2'h0};
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_writedata <= wd;
      // request stands until the rising edge that samples waitrequest low; data is taken there
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 20);
      rdat = o_avs_readdata;
      rsp = o_avs_response;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      if (n == 20) miscompares++;
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      repeat (4) @(posedge i_mclk);
      i_rst <= 1'b0;
      for (int j = 0; j < 4; j++) begin
         acc(0, j, 32'h0000_0000);
         chk(rdat, expv(j));
      end
      $display("reset values done");
      for (int i = 0; i < 40; i++) begin
         s = lfsr(s);
         k = s % 4;
         acc(1, k, {lfsr(s), s});
         if (k < 3) m[k] = {lfsr(s), s} & msk[k];
         drv <= s[6:0];
         repeat (6) @(posedge i_mclk);
         for (int j = 0; j < 4; j++) begin
            acc(0, j, 32'h0000_0000);
            chk(rdat, expv(j));
         end
         chk({13'h0, o_utmi_reset, o_phy_reset, o_flag_port_a, o_flag_port_b, o_phy_setup}, {13'h0, m[1][1],
            !m[1][0], m[2][1] ? p[3] : p[1], m[2][1] ? p[2] : p[0] & (p[1] | !m[2][0]), m[0][14:0]});
      end
      $display("random access done");
      acc(1, 4, 32'hffff_ffff);
      acc(0, 4, 32'h0000_0000);
      chk({rsp, rdat[29:0]}, 32'hc000_0000);
      acc(0, 0, 32'h0000_0000);
      chk(rdat, expv(0));
      $display("unmapped done");
      end_of_test();
   end
endmodule
